// file: srq_host.sv
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "srq_regs.svh"
module srq_host (
   input wire logic mclk,
   input wire logic reset,
   srq_link_if.host link,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b01,
      H_BUSY = 2'b10
   } host_state_e;
   host_state_e hs_q;
   host_state_e hs_d;
   logic aw_q, aw_d, w_q, w_d, b_q, b_d, ar_q, ar_d, r_q, r_d;
   logic [4:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic cv_q, cv_d, lis_q, lis_d;
   logic [1:0] cc_q, cc_d;
   logic [7:0] ca_q, ca_d, pollb_q, pollb_d;
   logic [1:0] ist_q, ist_d, imask_q, imask_d;
   logic irq_q, irq_d;
   logic srq_prev_q, srq_prev_d;

   function automatic logic mapped(input logic [4:0] a);
      mapped = (a == `OFF_CTRL) || (a == `OFF_MASK) || (a == `OFF_STATUS)
               || (a == `OFF_IRQ_STAT) || (a == `OFF_IRQ_MASK);
   endfunction

   always_comb
   begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      b_d = b_q;
      br_d = br_q;
      ar_d = 1'b1;
      r_d = r_q;
      rd_d = rd_q;
      rr_d = rr_q;
      hs_d = hs_q;
      cv_d = cv_q;
      cc_d = cc_q;
      ca_d = ca_q;
      lis_d = lis_q;
      pollb_d = pollb_q;
      imask_d = imask_q;
      ist_d = ist_q;
      if (s_axi_awvalid && !aw_q && !b_q)
      begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr[4:0];
      end
      if (s_axi_wvalid && !w_q && !b_q)
      begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (b_q && s_axi_bready)
      begin
         b_d = 1'b0;
      end
      if (aw_q && w_q && !b_q)
      begin
         aw_d = 1'b0;
         w_d = 1'b0;
         b_d = 1'b1;
         br_d = mapped(awa_q) ? 2'h0 : 2'h2;
         if (awa_q == `OFF_CTRL && hs_q == H_IDLE)
         begin
            // Control word: bits 1:0 command, 15:8 argument, 16 listen.
            cv_d = wd_q[1:0] != `CMD_NONE;
            cc_d = wd_q[1:0];
            ca_d = wd_q[15:8];
            lis_d = wd_q[16];
            if (wd_q[1:0] != `CMD_NONE)
            begin
               hs_d = H_BUSY;
            end
         end
         else if (awa_q == `OFF_IRQ_STAT)
         begin
            ist_d = ist_q & ~wd_q[1:0];
         end
         else if (awa_q == `OFF_IRQ_MASK)
         begin
            imask_d = wd_q[1:0];
         end
      end
      if (s_axi_arvalid && ar_q && !r_q)
      begin
         ar_d = 1'b0;
         r_d = 1'b1;
         rr_d = mapped(s_axi_araddr[4:0]) ? 2'h0 : 2'h2;
         case (s_axi_araddr[4:0])
            `OFF_CTRL: rd_d = {15'h0000, lis_q, ca_q, 6'h00, cc_q};
            `OFF_STATUS: rd_d = {23'h000000, hs_q == H_BUSY, pollb_q};
            `OFF_IRQ_STAT: rd_d = {30'h00000000, ist_q};
            `OFF_IRQ_MASK: rd_d = {30'h00000000, imask_q};
            default: rd_d = 32'h00000000;
         endcase
      end
      else if (r_q && s_axi_rready)
      begin
         r_d = 1'b0;
         ar_d = 1'b0;
      end
      else if (r_q)
      begin
         ar_d = 1'b0;
      end
      if (hs_q == H_BUSY && link.cmd_ready)
      begin
         cv_d = 1'b0;
         hs_d = H_IDLE;
         ist_d[0] = 1'b1;
      end
      if (link.poll_valid)
      begin
         pollb_d = link.poll_byte;
      end
      // Only the rise of the request is an event, so software can clear the bit while the
      // device still waits for its poll.
      srq_prev_d = link.service_request;
      if (link.service_request && !srq_prev_q)
      begin
         ist_d[1] = 1'b1;
      end
      irq_d = (ist_d & imask_d) != 2'h0;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         hs_q <= H_IDLE;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         b_q <= 1'b0;
         ar_q <= 1'b0;
         r_q <= 1'b0;
         awa_q <= 5'h00;
         wd_q <= 32'h00000000;
         rd_q <= 32'h00000000;
         br_q <= 2'h0;
         rr_q <= 2'h0;
         cv_q <= 1'b0;
         cc_q <= 2'h0;
         ca_q <= 8'h00;
         lis_q <= 1'b0;
         pollb_q <= 8'h00;
         ist_q <= 2'h0;
         imask_q <= 2'h0;
         irq_q <= 1'b0;
         srq_prev_q <= 1'b0;
      end
      else
      begin
         hs_q <= hs_d;
         aw_q <= aw_d;
         w_q <= w_d;
         b_q <= b_d;
         ar_q <= ar_d;
         r_q <= r_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         br_q <= br_d;
         rr_q <= rr_d;
         cv_q <= cv_d;
         cc_q <= cc_d;
         ca_q <= ca_d;
         lis_q <= lis_d;
         pollb_q <= pollb_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         irq_q <= irq_d;
         srq_prev_q <= srq_prev_d;
      end
   end

   // Ready is high only while the capture slot is empty.
   assign s_axi_awready = !aw_q && !b_q;
   assign s_axi_wready = !w_q && !b_q;
   assign s_axi_bvalid = b_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = ar_q && !r_q;
   assign s_axi_rvalid = r_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
   assign link.cmd_valid = cv_q;
   assign link.cmd_code = cc_q;
   assign link.cmd_arg = ca_q;
   assign link.listen = lis_q;
   assign irq = irq_q;
endmodule

// file: srq_regs.svh
`ifndef SRQ_REGS_SVH
`define SRQ_REGS_SVH
`define BIT_DATA_READY 0
`define BIT_POWER_ON 1
`define BIT_SELF_TEST 2
`define BIT_EVENT 3
`define BIT_LOW_BATT 4
`define BIT_ABNORMAL 5
`define BIT_RQS 6
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h00
`define UNMASKABLE 8'h14
`define MASKABLE 8'h29
`define OFF_CTRL 5'h00
`define OFF_MASK 5'h04
`define OFF_STATUS 5'h08
`define OFF_IRQ_STAT 5'h0c
`define OFF_IRQ_MASK 5'h10
`define CMD_NONE 2'h0
`define CMD_SET_MASK 2'h1
`define CMD_MON_LOW 2'h2
`define CMD_POLL 2'h3
`endif

// file: srq_pkg.sv
package srq_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [1:0] cmd_t;
endpackage

// file: srq_link_if.sv
`timescale 1ns/1ps
interface srq_link_if;
   logic cmd_valid;
   logic [1:0] cmd_code;
   logic [7:0] cmd_arg;
   logic cmd_ready;
   logic listen;
   logic service_request;
   logic poll_valid;
   logic [7:0] poll_byte;
   modport device (
      input cmd_valid, cmd_code, cmd_arg, listen,
      output cmd_ready, service_request, poll_valid, poll_byte
   );
   modport host (
      output cmd_valid, cmd_code, cmd_arg, listen,
      input cmd_ready, service_request, poll_valid, poll_byte
   );
endinterface

// file: srq_sync3.sv
`timescale 1ns/1ps
module srq_sync3 (
   input wire logic mclk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);
   logic [2:0] s_q;
   logic [2:0] s_d;
   logic out_q;
   logic out_d;
   always_comb
   begin
      s_d = {s_q[1:0], din};
      out_d = (s_q[2] == s_q[1]) ? s_q[1] : out_q;
   end
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_q <= 3'h7;
         out_q <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
         out_q <= out_d;
      end
   end
   assign dout = out_q;
endmodule

// file: srq_device.sv
`timescale 1ns/1ps
`include "srq_regs.svh"
module srq_device (
   input wire logic mclk,
   input wire logic reset,
   srq_link_if.device link,
   input wire logic data_ready,
   input wire logic power_on_event,
   input wire logic self_test_error,
   input wire logic low_battery,
   input wire logic extended_error,
   input wire logic srq_switch_up,
   input wire logic [31:0] digital_in,
   output logic [7:0] status_view
);
   typedef enum logic [2:0] {
      IDLE = 3'b001,
      CMD = 3'b010,
      POLL = 3'b100
   } dev_state_e;
   dev_state_e state_q;
   dev_state_e state_d;
   srq_pkg::byte_t status_q;
   srq_pkg::byte_t status_d;
   srq_pkg::byte_t mask_q;
   srq_pkg::byte_t mask_d;
   logic [4:0] mon_bit_q;
   logic [4:0] mon_bit_d;
   logic mon_on_q;
   logic mon_on_d;
   logic mon_prev_q;
   logic mon_prev_d;
   logic srq_q;
   logic srq_d;
   logic ready_q;
   logic ready_d;
   logic pv_q;
   logic pv_d;
   srq_pkg::byte_t pb_q;
   srq_pkg::byte_t pb_d;
   srq_pkg::byte_t raw_prev_q;
   srq_pkg::byte_t raw_prev_d;
   logic [7:0] raw;
   logic [7:0] ev;
   logic mon_level;
   logic [31:0] din_s;

   // Digital inputs come from outside the clock domain.
   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1)
      begin : gsync
         srq_sync3 srq_sync3_i (
            .mclk(mclk),
            .reset(reset),
            .din(digital_in[g]),
            .dout(din_s[g])
         );
      end
   endgenerate

   assign mon_level = din_s[mon_bit_q];

   // The mask can hide bits 0, 3 and 5 only; power-on answers to the switch alone.
   function automatic logic request_due(
      input srq_pkg::byte_t fresh,
      input srq_pkg::byte_t enables,
      input logic switch_up
   );
      begin
         request_due = ((fresh & enables & `MASKABLE) != 8'h00)
                       || ((fresh & `UNMASKABLE) != 8'h00)
                       || (fresh[`BIT_POWER_ON] && switch_up);
      end
   endfunction

   always_comb
   begin
      raw = 8'h00;
      raw[`BIT_DATA_READY] = data_ready;
      raw[`BIT_POWER_ON] = power_on_event;
      raw[`BIT_SELF_TEST] = self_test_error;
      raw[`BIT_LOW_BATT] = low_battery;
      raw[`BIT_EVENT] = mon_on_q & mon_prev_q & ~mon_level;
      raw[`BIT_ABNORMAL] = extended_error | self_test_error | low_battery;
      state_d = state_q;
      mask_d = mask_q;
      mon_bit_d = mon_bit_q;
      mon_on_d = mon_on_q;
      mon_prev_d = mon_level;
      ready_d = 1'b0;
      pv_d = 1'b0;
      pb_d = pb_q;
      raw_prev_d = raw;
      status_d = status_q | raw;
      if (extended_error | status_d[`BIT_SELF_TEST] | status_d[`BIT_LOW_BATT])
      begin
         status_d[`BIT_ABNORMAL] = 1'b1;
      end
      // A condition requests on its rising edge, so a repeat after a poll is heard again
      // even though its sticky status bit was never cleared.
      ev = raw & ~raw_prev_q;
      srq_d = srq_q;
      case (state_q)
         IDLE:
         begin
            // Valid still stands in the cycle of our ready pulse; taking it there runs it twice.
            if (link.cmd_valid && !ready_q)
            begin
               state_d = (link.cmd_code == `CMD_POLL) ? POLL : CMD;
            end
         end
         CMD:
         begin
            ready_d = 1'b1;
            state_d = IDLE;
            if (link.cmd_code == `CMD_SET_MASK)
            begin
               mask_d = link.cmd_arg & `MASKABLE;
            end
            else if (link.cmd_code == `CMD_MON_LOW)
            begin
               mon_bit_d = link.cmd_arg[4:0];
               mon_on_d = 1'b1;
            end
         end
         POLL:
         begin
            ready_d = 1'b1;
            pv_d = 1'b1;
            pb_d = status_q;
            status_d[`BIT_RQS] = 1'b0;
            srq_d = 1'b0;
            state_d = IDLE;
         end
         default:
         begin
            state_d = IDLE;
         end
      endcase
      if (request_due(ev, mask_q, srq_switch_up))
      begin
         status_d[`BIT_RQS] = 1'b1;
      end
      status_d[7] = 1'b0;
      // Request stays pending until the host has stopped addressing us.
      if (status_d[`BIT_RQS] && !link.listen)
      begin
         srq_d = 1'b1;
      end
      if (!status_d[`BIT_RQS])
      begin
         srq_d = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_q <= IDLE;
         status_q <= `STATUS_RESET;
         mask_q <= `MASK_RESET;
         mon_bit_q <= 5'h00;
         mon_on_q <= 1'b0;
         mon_prev_q <= 1'b1;
         srq_q <= 1'b0;
         ready_q <= 1'b0;
         pv_q <= 1'b0;
         pb_q <= 8'h00;
         raw_prev_q <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         status_q <= status_d;
         mask_q <= mask_d;
         mon_bit_q <= mon_bit_d;
         mon_on_q <= mon_on_d;
         mon_prev_q <= mon_prev_d;
         srq_q <= srq_d;
         ready_q <= ready_d;
         pv_q <= pv_d;
         pb_q <= pb_d;
         raw_prev_q <= raw_prev_d;
      end
   end

   assign link.cmd_ready = ready_q;
   assign link.service_request = srq_q;
   assign link.poll_valid = pv_q;
   assign link.poll_byte = pb_q;
   assign status_view = status_q;
endmodule

// file: srq_link_assertions.sv
`timescale 1ns/1ps
module srq_link_assertions (
   input wire logic mclk,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_code,
   input wire logic cmd_ready,
   input wire logic listen,
   input wire logic service_request,
   input wire logic poll_valid,
   input wire logic [7:0] poll_byte
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   a_top_bit_zero: assert property (poll_valid |-> !poll_byte[7])
      else $error("poll byte bit 7 set");
   a_flag_in_byte: assert property (poll_valid && $past(service_request) |-> poll_byte[6])
      else $error("request flag missing from poll byte");
   a_drop_by_poll: assert property ($fell(service_request) |-> poll_valid || $past(poll_valid))
      else $error("service request dropped without a poll");
   a_poll_on_cmd: assert property (poll_valid |-> cmd_ready && cmd_valid && cmd_code == 2'h3)
      else $error("poll byte without a poll command");
   a_ready_pulse: assert property (cmd_ready |=> !cmd_ready)
      else $error("command ready longer than one cycle");
   a_ready_bound: assert property ($rose(cmd_valid) |-> ##[1:3] cmd_ready)
      else $error("command not answered in time");
   a_ready_needs_cmd: assert property (cmd_ready |-> cmd_valid)
      else $error("command ready with no command");
   a_quiet_listener: assert property ($past(listen) |-> !$rose(service_request))
      else $error("service request raised while addressed as listener");

   c_flagged_poll: cover property (poll_valid && poll_byte[6]);
   c_request: cover property ($rose(service_request));
   c_listen_cmd: cover property (listen && cmd_ready);
endmodule

// file: tb_service_request_status_unit.sv
`timescale 1ns/1ps
module tb_service_request_status_unit;
   logic mclk, reset, sw, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, wr_resp, rd_resp;
   logic [4:0] cond;
   logic [7:0] view;
   logic [31:0] din, awaddr, wdata, araddr, rdata, rd_data;
   int err_count, cmp_count;

   srq_link_if link();
   srq_device srq_device_i (.mclk(mclk), .reset(reset), .link(link), .data_ready(cond[0]),
      .power_on_event(cond[1]), .self_test_error(cond[2]), .extended_error(cond[3]),
      .low_battery(cond[4]), .srq_switch_up(sw), .digital_in(din), .status_view(view));
   srq_host srq_host_i (.mclk(mclk), .reset(reset), .link(link), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
   srq_link_assertions srq_link_assertions_i (.mclk(mclk), .reset(reset),
      .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_ready(link.cmd_ready),
      .listen(link.listen), .service_request(link.service_request),
      .poll_valid(link.poll_valid), .poll_byte(link.poll_byte));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic close_out();
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         cmp_count++;
         if (got !== exp)
         begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            err_count++;
         end
      end
   endtask

   task automatic rst();
      begin
         reset <= 1'b1;
         repeat (3) @(posedge mclk);
         reset <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask

   // Both tasks spend one idle edge at the end so a following call never reassigns a strobe
   // in the same time step.
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         forever
         begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
         end
         bready <= 1'b0;
         wr_resp = bresp;
         @(posedge mclk);
      end
   endtask

   task automatic axi_rd(input logic [31:0] a);
      begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         forever
         begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
         end
         rready <= 1'b0;
         rd_data = rdata;
         rd_resp = rresp;
         @(posedge mclk);
      end
   endtask

   task automatic cmd(input logic [1:0] c, input logic [7:0] a, input logic l);
      begin
         axi_wr(32'h0, {15'h0, l, a, 6'h0, c});
         axi_rd(32'h8);
         while (rd_data[8] !== 1'b0) axi_rd(32'h8);
      end
   endtask

   task automatic poll(input logic [7:0] exp);
      begin
         cmd(2'h3, 8'h00, 1'b0);
         chk(rd_data[7:0], exp);
      end
   endtask

   task automatic pulse(input logic [4:0] m);
      begin
         cond <= m;
         @(posedge mclk);
         cond <= 5'h00;
         @(posedge mclk);
      end
   endtask

   task automatic wait_srq();
      while (link.service_request !== 1'b1) @(posedge mclk);
   endtask

   task automatic t_event();
      begin
         rst();
         axi_wr(32'h18, 32'h0);
         chk({6'h0, wr_resp}, 8'h02);
         axi_rd(32'h18);
         chk({6'h0, rd_resp}, 8'h02);
         axi_wr(32'h10, 32'h2);
         cmd(2'h1, 8'h09, 1'b0);
         cmd(2'h2, 8'h11, 1'b0);
         din[17] <= 1'b0;
         while (view[3] !== 1'b1) @(posedge mclk);
         pulse(5'h01);
         wait_srq();
         axi_rd(32'hc);
         chk(rd_data[7:0], 8'h03);
         chk({7'h0, irq}, 8'h01);
         chk(view, 8'h49);
         axi_wr(32'hc, 32'h3);
         axi_rd(32'hc);
         chk(rd_data[7:0], 8'h00);
         chk({7'h0, irq}, 8'h00);
         poll(8'h49);
         poll(8'h09);
         din[17] <= 1'b1;
      end
   endtask

   task automatic t_unmask(input logic [4:0] m, input logic [7:0] exp);
      begin
         rst();
         pulse(m);
         wait_srq();
         poll(exp);
      end
   endtask

   task automatic t_masked();
      begin
         rst();
         sw <= 1'b0;
         pulse(5'h0b);
         cmd(2'h1, 8'h00, 1'b0);
         chk({7'h0, link.service_request}, 8'h00);
         poll(8'h23);
         sw <= 1'b1;
         pulse(5'h02);
         wait_srq();
         poll(8'h63);
      end
   endtask

   task automatic t_listen();
      begin
         rst();
         cmd(2'h1, 8'h01, 1'b1);
         pulse(5'h01);
         cmd(2'h1, 8'h01, 1'b1);
         chk({7'h0, link.service_request}, 8'h00);
         cmd(2'h1, 8'h01, 1'b0);
         wait_srq();
         poll(8'h41);
      end
   endtask

   initial
   begin
      reset = 1'b1;
      sw = 1'b1;
      cond = 5'h00;
      din = 32'hffffffff;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr} = 96'h0;
      err_count = 0;
      cmp_count = 0;
      t_event();
      t_unmask(5'h04, 8'h64);
      t_unmask(5'h10, 8'h70);
      t_masked();
      t_listen();
      close_out();
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      err_count++;
      close_out();
   end
endmodule
